// *** hw/dpts_core.sv ***
// profile table sequencer, command execution and four-channel synthesizer core
//
// What this block does
// R1: phase-clear mode zeroes accumulators after each command
// R2: phase-keep mode, default, leaves accumulators running
// R3: auto mode issues update after every command
// R4: manual mode updates only on pulse command
// R5: external mode updates on trigger rising edge
// R6: table holds 32768 four-field profiles
// R7: table mode drives only channels zero, one
// R8: single-tone command always leaves table mode
// R9: table-run command enters, then toggles execution
// R10: load records carry address; host pairs channels
// R11: frequency field is 32-bit, 0.1 Hz lsb
// R12: phase field uses low 14 bits
// R13: amplitude field uses low 10 bits
// R14: dwell counts 100us; 00 wraps, ff holds
// R15: host keeps pair dwell equal, formats records
// R16: execution starts at 0000, advances until 00/ff
// R17: dwell 00 profile lasts one interval, wraps
// R18: all-ff table advances one pair per step
// R19: step trigger falling edge acts as step command
// R20: host ends every table with 00 or ff
// R21: readback returns stored profile at address
// R22: accumulate each cycle, map sine, 10-bit code
// R23: increment is frequency word times multiplier
// R24: multiplier accepts only 1 or 4..20
// R25: dwell tick counter reloads on each advance
// R26: pair applied together with one update
`timescale 1ns/1ps
`default_nettype none
module dpts_core import dpts_pkg::*; (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// decoded host command
	input wire logic cmd_valid_in,
	input wire dpts_cmd_s cmd_in,
	// rear trigger pins
	input wire logic update_trigger_pin_in,
	input wire logic table_step_pin_in,
	// converter codes, channel n in bits [n*10 +: 10]
	output logic [NCHAN*DAC_W-1:0] dac_out,
	// update pulse to the synthesizer core
	output logic update_pulse_out,
	// readback
	output logic rb_valid_out,
	output dpts_prof_s rb_data_out,
	// status
	output logic table_mode_out,
	output logic table_running_out,
	output logic [TADDR_W-1:0] table_addr_out,
	output logic [7:0] pll_multiplier_out,
	output logic phase_clear_mode_out,
	output logic [1:0] upd_mode_out,
	output logic cmd_err_out
);
	// quarter-wave sine magnitude, 9 bits
	function automatic logic [8:0] sine_quarter(input logic [3:0] idx);
		logic [8:0] m;
		m = 9'h000;
		case (idx)
			4'h0: m = 9'h019; 4'h1: m = 9'h04b; 4'h2: m = 9'h07c; 4'h3: m = 9'h0ac;
			4'h4: m = 9'h0da; 4'h5: m = 9'h107; 4'h6: m = 9'h130; 4'h7: m = 9'h157;
			4'h8: m = 9'h17b; 4'h9: m = 9'h19a; 4'ha: m = 9'h1b6; 4'hb: m = 9'h1ce;
			4'hc: m = 9'h1e1; 4'hd: m = 9'h1f0; 4'he: m = 9'h1f9; default: m = 9'h1fe;
		endcase
		return m;
	endfunction

	// phase to scaled offset-binary converter code
	function automatic logic [DAC_W-1:0] sine_code(input logic [5:0] ph,
			input logic [AMP_W-1:0] amp);
		logic [3:0] idx;
		logic [18:0] prod;
		logic [8:0] mag;
		idx = ph[4] ? ~ph[3:0] : ph[3:0];
		prod = 19'(sine_quarter(idx)) * 19'(amp);
		mag = prod[18:10];
		return ph[5] ? DAC_MID - 10'(mag) : DAC_MID + 10'(mag);
	endfunction

	// R24: legal multiplier values
	function automatic logic mult_ok(input logic [7:0] k);
		return (k == MULT_BYPASS) || ((k >= MULT_MIN) && (k <= MULT_MAX));
	endfunction

	// R23: per-cycle increment, system clock folded into the step
	function automatic logic [31:0] phase_inc(input logic [31:0] fw, input logic [7:0] k);
		logic [39:0] p;
		p = 40'(fw) * 40'(k);
		return p[31:0];
	endfunction

	// state
	dpts_sq_e sq_q, sq_d;
	dpts_upd_e upd_mode_q;
	dpts_chan_s pend_q [NCHAN];
	dpts_chan_s act_q [NCHAN];
	logic [31:0] acc_q [NCHAN];
	logic [DAC_W-1:0] dac_q [NCHAN];
	logic [TADDR_W-1:0] addr_q, addr_d;
	logic [7:0] dwell_q, mult_q;
	logic [11:0] tick_q;
	logic wrap_q, pc_q, upd_q, rb_valid_q, err_q;
	dpts_prof_s rb_q;
	dpts_prof_s prof_rd_q [2];
	// R6: profile storage, one array per table channel
	dpts_prof_s tbl_mem [2][TABLE_DEPTH];
	logic [2:0] ext_sync_q, step_sync_q;
	logic ext_lvl_q, step_lvl_q;
	logic tbl_mode_q, tbl_run_q;

	// command decode
	wire cmd_w = cmd_valid_in;
	wire is_single = cmd_w && (cmd_in.op == OP_MODE_SINGLE);
	wire is_table = cmd_w && (cmd_in.op == OP_MODE_TABLE);
	wire is_step = cmd_w && (cmd_in.op == OP_TABLE_STEP);
	wire is_pulse = cmd_w && (cmd_in.op == OP_UPD_PULSE);
	wire is_load = cmd_w && ((cmd_in.op == OP_LOAD_CH_ZERO) || (cmd_in.op == OP_LOAD_CH_ONE));
	wire is_rb = cmd_w && (cmd_in.op == OP_READBACK);
	wire is_mult = cmd_w && (cmd_in.op == OP_SET_MULT);
	wire load_ch = (cmd_in.op == OP_LOAD_CH_ONE);
	wire [TADDR_W-1:0] cmd_addr = cmd_in.addr[TADDR_W-1:0];
	wire tbl_on = (sq_q != SQ_SINGLE);
	wire tbl_apply = (sq_q == SQ_APPLY);
	wire tick_w = (sq_q == SQ_DWELL) && (tick_q == DWELL_TICK_LAST);
	wire [7:0] apply_dwell = prof_rd_q[0].dwell_field;

	// trigger pins: level changes once second and third stages agree
	wire ext_agree = (ext_sync_q[1] == ext_sync_q[2]);
	wire step_agree = (step_sync_q[1] == step_sync_q[2]);
	wire ext_rise = ext_agree && ext_sync_q[2] && !ext_lvl_q;
	// R19: falling edge of step pin stands in for the step command
	wire step_fall = step_agree && !step_sync_q[2] && step_lvl_q;
	wire step_any = is_step || step_fall;

	// synchronisers and filtered levels
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			ext_sync_q <= 3'h0;
			step_sync_q <= 3'h7;
			ext_lvl_q <= 1'b0;
			step_lvl_q <= 1'b1;
		end else begin
			ext_sync_q <= {ext_sync_q[1:0], update_trigger_pin_in};
			step_sync_q <= {step_sync_q[1:0], table_step_pin_in};
			ext_lvl_q <= ext_agree ? ext_sync_q[2] : ext_lvl_q;
			step_lvl_q <= step_agree ? step_sync_q[2] : step_lvl_q;
		end
	end

	// R3 R4 R5: update source by mode; R26 table apply shares it
	wire upd_fire = (upd_mode_q == UPD_AUTO) ? (cmd_w || tbl_apply) :
		(upd_mode_q == UPD_MANUAL) ? is_pulse : ext_rise;
	// R1 R2: phase clear only in clear mode, at command completion
	wire acc_clr = pc_q && cmd_w;

	// sequencer next state, host commands take priority
	always_comb begin
		sq_d = sq_q;
		addr_d = addr_q;
		if (is_single) begin
			// R8: leave table mode from anywhere
			sq_d = SQ_SINGLE;
		end else if (is_table) begin
			// R9 R16: enter or restart at 0000, else pause
			if ((sq_q == SQ_SINGLE) || (sq_q == SQ_PAUSE)) begin
				sq_d = SQ_FETCH;
				addr_d = '0;
			end else begin
				sq_d = SQ_PAUSE;
			end
		end else begin
			unique case (sq_q)
				SQ_SINGLE, SQ_PAUSE: sq_d = sq_q;
				SQ_FETCH: sq_d = SQ_APPLY;
				// R14: ff holds, any other value dwells
				SQ_APPLY: sq_d = (apply_dwell == DWELL_HOLD) ? SQ_HOLD : SQ_DWELL;
				SQ_DWELL: begin
					// R17: wrap after the last interval of a 00 profile
					if (tick_w && (dwell_q == 8'h01)) begin
						sq_d = SQ_FETCH;
						addr_d = wrap_q ? '0 : TADDR_W'(addr_q + 1'b1);
					end
				end
				SQ_HOLD: begin
					// R18: one pair per step
					if (step_any) begin
						sq_d = SQ_FETCH;
						addr_d = TADDR_W'(addr_q + 1'b1);
					end
				end
				default: sq_d = SQ_SINGLE;
			endcase
		end
	end

	// sequencer registers and dwell timing
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			sq_q <= SQ_SINGLE;
			addr_q <= '0;
			dwell_q <= 8'h00;
			tick_q <= 12'h000;
			wrap_q <= 1'b0;
			tbl_mode_q <= 1'b0;
			tbl_run_q <= 1'b0;
		end else begin
			sq_q <= sq_d;
			addr_q <= addr_d;
			// status levels registered from the next state
			tbl_mode_q <= (sq_d != SQ_SINGLE);
			tbl_run_q <= (sq_d != SQ_SINGLE) && (sq_d != SQ_PAUSE);
			// R25: tick counter restarts on each applied profile
			if (tbl_apply) begin
				tick_q <= 12'h000;
				wrap_q <= (apply_dwell == DWELL_WRAP);
				dwell_q <= (apply_dwell == DWELL_WRAP) ? 8'h01 : apply_dwell;
			end else if (sq_q == SQ_DWELL) begin
				tick_q <= tick_w ? 12'h000 : 12'(tick_q + 1'b1);
				dwell_q <= tick_w ? 8'(dwell_q - 1'b1) : dwell_q;
			end
		end
	end

	// R6 R10: table writes at the record address; reads both channels at addr_q for fetch
	always_ff @(posedge core_clk_in) begin
		if (is_load) begin
			tbl_mem[load_ch][cmd_addr] <= cmd_in.prof;
		end
		prof_rd_q[0] <= tbl_mem[0][addr_q];
		prof_rd_q[1] <= tbl_mem[1][addr_q];
	end

	// modes, readback, multiplier and error flag
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			pc_q <= 1'b0;
			upd_mode_q <= UPD_AUTO;
			mult_q <= MULT_RESET;
			rb_valid_q <= 1'b0;
			rb_q <= '0;
			err_q <= 1'b0;
			upd_q <= 1'b0;
		end else begin
			upd_q <= upd_fire;
			rb_valid_q <= is_rb;
			err_q <= is_mult && !mult_ok(cmd_in.value[7:0]);
			if (cmd_w && (cmd_in.op == OP_PHASE_CLEAR)) pc_q <= 1'b1;
			if (cmd_w && (cmd_in.op == OP_PHASE_KEEP)) pc_q <= 1'b0;
			if (cmd_w && (cmd_in.op == OP_UPD_AUTO)) upd_mode_q <= UPD_AUTO;
			if (cmd_w && (cmd_in.op == OP_UPD_MANUAL)) upd_mode_q <= UPD_MANUAL;
			if (cmd_w && (cmd_in.op == OP_UPD_EXT)) upd_mode_q <= UPD_EXT;
			// R24: illegal multiplier is refused
			if (is_mult && mult_ok(cmd_in.value[7:0])) mult_q <= cmd_in.value[7:0];
			// R21: readback of the named channel and address
			if (is_rb) rb_q <= tbl_mem[cmd_in.chan[0]][cmd_addr];
		end
	end

	// pending and active channel settings, synthesizer accumulators
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			for (int c = 0; c < NCHAN; c++) begin
				pend_q[c] <= '{freq: 32'h0, phase: '0, amp: AMP_RESET};
				act_q[c] <= '{freq: 32'h0, phase: '0, amp: AMP_RESET};
				acc_q[c] <= 32'h0;
				dac_q[c] <= DAC_MID;
			end
		end else begin
			for (int c = 0; c < NCHAN; c++) begin
				// R22: add increment each cycle, phase offset, sine code
				acc_q[c] <= acc_clr ? 32'h0 : acc_q[c] + phase_inc(act_q[c].freq, mult_q);
				dac_q[c] <= sine_code(6'(acc_q[c][31:ACC_PH_LSB] + act_q[c].phase >> 8),
					act_q[c].amp);
				if (upd_q) act_q[c] <= pend_q[c];
			end
			// R7: channels two and three idle in table mode
			if (tbl_on) begin
				dac_q[2] <= DAC_MID;
				dac_q[3] <= DAC_MID;
			end
			// R26 R11 R12 R13: pair loaded together from the fetched profiles
			if (tbl_apply) begin
				for (int c = 0; c < 2; c++) begin
					pend_q[c].freq <= prof_rd_q[c].freq;
					pend_q[c].phase <= prof_rd_q[c].phase[PHASE_W-1:0];
					pend_q[c].amp <= prof_rd_q[c].amp[AMP_W-1:0];
				end
			end else if (cmd_w) begin
				if (cmd_in.op == OP_SET_FREQ) pend_q[cmd_in.chan].freq <= cmd_in.value;
				if (cmd_in.op == OP_SET_PHASE)
					pend_q[cmd_in.chan].phase <= cmd_in.value[PHASE_W-1:0];
				if (cmd_in.op == OP_SET_AMP) pend_q[cmd_in.chan].amp <= cmd_in.value[AMP_W-1:0];
			end
		end
	end

	// outputs straight from flip-flops
	always_comb begin
		for (int c = 0; c < NCHAN; c++) dac_out[c*DAC_W +: DAC_W] = dac_q[c];
	end
	assign update_pulse_out = upd_q;
	assign rb_valid_out = rb_valid_q;
	assign rb_data_out = rb_q;
	assign table_mode_out = tbl_mode_q;
	assign table_running_out = tbl_run_q;
	assign table_addr_out = addr_q;
	assign pll_multiplier_out = mult_q;
	assign phase_clear_mode_out = pc_q;
	assign upd_mode_out = upd_mode_q;
	assign cmd_err_out = err_q;

	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	phase_clear_a: assert property (acc_clr |=> acc_q[0] == 32'h0 && acc_q[1] == 32'h0) // R1
		else $error("accumulators not cleared after command");
	phase_keep_a: assert property (!pc_q && cmd_w && act_q[0].freq != 32'h0 && !upd_q
		|=> acc_q[0] != $past(acc_q[0])) // R2
		else $error("accumulator stalled in keep mode");
	auto_upd_a: assert property (upd_mode_q == UPD_AUTO && cmd_w |=> update_pulse_out) // R3
		else $error("no update after command in auto mode");
	manual_hold_a: assert property (upd_mode_q == UPD_MANUAL && !is_pulse |=> !update_pulse_out) // R4
		else $error("update without pulse command");
	ext_upd_a: assert property (upd_mode_q == UPD_EXT |=> update_pulse_out == $past(ext_rise)) // R5
		else $error("external update mismatch");
	ch_idle_a: assert property (tbl_on && $past(tbl_on) |-> dac_q[2] == DAC_MID) // R7
		else $error("channel two active in table mode");
	single_exit_a: assert property (is_single |=> sq_q == SQ_SINGLE ##1 !table_mode_out) // R8
		else $error("single-tone command ignored");
	table_start_a: assert property (is_table && !table_running_out
		|=> sq_q == SQ_FETCH && addr_q == '0 ##1 sq_q == SQ_APPLY) // R9
		else $error("table run did not start at zero");
	hold_ff_a: assert property (tbl_apply && apply_dwell == DWELL_HOLD && !cmd_w
		|=> sq_q == SQ_HOLD) // R14
		else $error("ff dwell did not hold");
	wrap_zero_a: assert property (tick_w && wrap_q && !cmd_w |=> sq_q == SQ_FETCH && addr_q == '0) // R17
		else $error("00 dwell did not wrap");
	step_adv_a: assert property (sq_q == SQ_HOLD && step_any && !is_single && !is_table
		|=> sq_q == SQ_FETCH && addr_q == TADDR_W'($past(addr_q) + 1'b1)) // R19
		else $error("step did not advance one profile");
	tick_gap_a: assert property (tick_w |=> !tick_w [*8]) // R25
		else $error("dwell ticks too close");
	mult_legal_a: assert property (mult_ok(mult_q)) // R24
		else $error("illegal multiplier held");
	readback_a: assert property (is_rb |=> rb_valid_out ##1 !rb_valid_out || $past(is_rb)) // R21
		else $error("readback not answered");

	run_hold_c: cover property (tbl_apply ##1 sq_q == SQ_HOLD ##[1:20] step_fall);
	wrap_c: cover property (tick_w && wrap_q ##1 addr_q == '0);
	ext_c: cover property (upd_mode_q == UPD_EXT && ext_rise);
	rb_c: cover property (is_rb ##1 rb_valid_out);
endmodule
`default_nettype wire

// *** pkg/dpts_pkg.sv ***
// shared constants and types of the profile table sequencer
package dpts_pkg;
	// clock and dwell timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int DWELL_UNIT_NS = 100000;
	localparam int DWELL_TICK_CYC = (DWELL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] DWELL_TICK_LAST = 12'(DWELL_TICK_CYC - 1);
	// table size and field widths
	localparam int TABLE_DEPTH = 32768;
	localparam int TADDR_W = 15;
	localparam int PHASE_W = 14;
	localparam int AMP_W = 10;
	localparam int DAC_W = 10;
	localparam int NCHAN = 4;
	// dwell codes
	localparam logic [7:0] DWELL_WRAP = 8'h00;
	localparam logic [7:0] DWELL_HOLD = 8'hff;
	// clock multiplier limits and reset values
	localparam logic [7:0] MULT_BYPASS = 8'h01;
	localparam logic [7:0] MULT_MIN = 8'h04;
	localparam logic [7:0] MULT_MAX = 8'h14;
	localparam logic [7:0] MULT_RESET = 8'h0f;
	localparam logic [AMP_W-1:0] AMP_RESET = 10'h3ff;
	localparam logic [DAC_W-1:0] DAC_MID = 10'h200;
	localparam int ACC_PH_LSB = 32 - PHASE_W;
	// host commands, already decoded from the serial text
	typedef enum logic [3:0] {
		OP_SET_FREQ = 4'h0, OP_SET_PHASE = 4'h1, OP_SET_AMP = 4'h2,
		OP_MODE_SINGLE = 4'h3, OP_MODE_TABLE = 4'h4, OP_PHASE_CLEAR = 4'h5,
		OP_PHASE_KEEP = 4'h6, OP_UPD_AUTO = 4'h7, OP_UPD_MANUAL = 4'h8,
		OP_UPD_EXT = 4'h9, OP_UPD_PULSE = 4'ha, OP_TABLE_STEP = 4'hb,
		OP_LOAD_CH_ZERO = 4'hc, OP_LOAD_CH_ONE = 4'hd, OP_READBACK = 4'he,
		OP_SET_MULT = 4'hf
	} dpts_op_e;
	typedef enum logic [1:0] {UPD_AUTO = 2'h0, UPD_MANUAL = 2'h1, UPD_EXT = 2'h2} dpts_upd_e;
	// sequencer states
	typedef enum logic [5:0] {
		SQ_SINGLE = 6'h01, SQ_FETCH = 6'h02, SQ_APPLY = 6'h04,
		SQ_DWELL = 6'h08, SQ_HOLD = 6'h10, SQ_PAUSE = 6'h20
	} dpts_sq_e;
	typedef struct packed {
		logic [31:0] freq;
		logic [15:0] phase;
		logic [15:0] amp;
		logic [7:0] dwell_field;
	} dpts_prof_s;
	typedef struct packed {
		dpts_op_e op;
		logic [1:0] chan;
		logic [15:0] addr;
		logic [31:0] value;
		dpts_prof_s prof;
	} dpts_cmd_s;
	typedef struct packed {
		logic [31:0] freq;
		logic [PHASE_W-1:0] phase;
		logic [AMP_W-1:0] amp;
	} dpts_chan_s;
endpackage

// *** sim/dpts_host.sv ***
// host model: issues decoded commands and profile records to the sequencer
`timescale 1ns/1ps
`default_nettype none
module dpts_host import dpts_pkg::*; (
	// clock
	input wire logic core_clk_in,
	// decoded command towards the device
	output logic cmd_valid_out,
	output dpts_cmd_s cmd_out
);
	// idle command port
	initial begin
		cmd_valid_out = 1'b0;
		cmd_out = '0;
	end
	// one command, held for exactly one taking edge
	task automatic send(input dpts_op_e op, input logic [1:0] chan, input logic [15:0] addr,
			input logic [31:0] value, input dpts_prof_s prof);
		@(posedge core_clk_in);
		cmd_valid_out <= 1'b1;
		cmd_out <= '{op: op, chan: chan, addr: addr, value: value, prof: prof};
		@(posedge core_clk_in);
		cmd_valid_out <= 1'b0;
		// released fields never keep their last value
		cmd_out <= dpts_cmd_s'(~cmd_out);
	endtask
	// one profile pair: both channel records for one address
	task automatic load_pair(input logic [15:0] addr, input logic [31:0] freq,
			input logic [15:0] phase, input logic [15:0] amp, input logic [7:0] dwell);
		dpts_prof_s p;
		p = '{freq: freq, phase: phase, amp: amp, dwell_field: dwell};
		send(OP_LOAD_CH_ZERO, 2'h0, addr, 32'h0, p);
		send(OP_LOAD_CH_ONE, 2'h1, addr, 32'h0, p);
	endtask
endmodule
`default_nettype wire

// *** sim/test_dpts_core.sv ***
// self-checking bench of the profile table sequencer
`timescale 1ns/1ps
`default_nettype none
module test_dpts_core import dpts_pkg::*;;
	typedef struct packed {
		dpts_op_e op;
		logic [7:0] val;
		logic err;
		logic [7:0] mult;
		logic pcm;
		logic [1:0] upd;
	} dpts_row_s;
	logic core_clk_in, rst_n_in, cmd_valid, update_trigger_pin, table_step_pin;
	dpts_cmd_s cmd;
	logic [NCHAN*DAC_W-1:0] dac_out;
	logic update_pulse_out, rb_valid_out, table_mode_out, table_running_out;
	logic phase_clear_mode_out, cmd_err_out;
	dpts_prof_s rb_data_out;
	logic [TADDR_W-1:0] table_addr_out;
	logic [7:0] pll_multiplier_out;
	logic [1:0] upd_mode_out;
	logic [9:0] dac_keep;
	int error_cnt = 0;
	int cmp_count = 0;
	int upd_cnt = 0;
	int base = 0;
	dpts_row_s rows [0:12] = '{
		'{OP_SET_MULT, 8'h01, 1'b0, 8'h01, 1'b0, 2'h0}, '{OP_SET_MULT, 8'h00, 1'b1, 8'h01, 1'b0, 2'h0},
		'{OP_SET_MULT, 8'h03, 1'b1, 8'h01, 1'b0, 2'h0}, '{OP_SET_MULT, 8'h04, 1'b0, 8'h04, 1'b0, 2'h0},
		'{OP_SET_MULT, 8'h14, 1'b0, 8'h14, 1'b0, 2'h0}, '{OP_SET_MULT, 8'h15, 1'b1, 8'h14, 1'b0, 2'h0},
		'{OP_SET_MULT, 8'h0f, 1'b0, 8'h0f, 1'b0, 2'h0}, '{OP_PHASE_CLEAR, 8'h0, 1'b0, 8'h0f, 1'b1, 2'h0},
		'{OP_PHASE_KEEP, 8'h0, 1'b0, 8'h0f, 1'b0, 2'h0}, '{OP_UPD_MANUAL, 8'h0, 1'b0, 8'h0f, 1'b0, 2'h1},
		'{OP_UPD_EXT, 8'h0, 1'b0, 8'h0f, 1'b0, 2'h2}, '{OP_UPD_AUTO, 8'h0, 1'b0, 8'h0f, 1'b0, 2'h0},
		'{OP_SET_MULT, 8'hff, 1'b1, 8'h0f, 1'b0, 2'h0}};
	// clock, 40 ns period
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	// count update pulses
	always @(posedge core_clk_in) begin
		if (update_pulse_out === 1'b1) begin
			upd_cnt <= upd_cnt + 1;
		end
	end
	dpts_host i_dpts_host (.core_clk_in(core_clk_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
	dpts_core i_dpts_core (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
		.update_trigger_pin_in(update_trigger_pin), .table_step_pin_in(table_step_pin),
		.dac_out(dac_out), .update_pulse_out(update_pulse_out), .rb_valid_out(rb_valid_out),
		.rb_data_out(rb_data_out), .table_mode_out(table_mode_out),
		.table_running_out(table_running_out), .table_addr_out(table_addr_out),
		.pll_multiplier_out(pll_multiplier_out), .phase_clear_mode_out(phase_clear_mode_out),
		.upd_mode_out(upd_mode_out), .cmd_err_out(cmd_err_out));
	// verdict and end of run
	task automatic final_report();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// compare and report
	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk_in);
	endtask
	task automatic dchk(input int n);
		chk(72'(upd_cnt - base), 72'(n));
	endtask
	// wait for a table address, checking the elapsed cycles
	task automatic wait_addr(input logic [14:0] exp, input int lo, input int hi);
		int n;
		n = 0;
		while (table_addr_out !== exp && n < hi) begin
			@(negedge core_clk_in);
			n++;
		end
		chk(72'(n >= lo && n < hi), 72'h1);
	endtask
	// hang guard
	initial begin
		#1000000;
		error_cnt++;
		final_report();
	end
	// main sequence
	initial begin
		rst_n_in = 1'b0;
		update_trigger_pin = 1'b0;
		table_step_pin = 1'b1;
		repeat (9) @(posedge core_clk_in);
		@(negedge core_clk_in);
		chk(72'(dac_out), 72'({4{DAC_MID}}));
		chk(72'({pll_multiplier_out, phase_clear_mode_out, upd_mode_out}), 72'({MULT_RESET, 3'h0}));
		@(posedge core_clk_in);
		rst_n_in <= 1'b1;
		// settings table
		for (int i = 0; i < 13; i++) begin
			i_dpts_host.send(rows[i].op, 2'h0, 16'h0, 32'(rows[i].val), '0);
			@(negedge core_clk_in);
			chk(72'(cmd_err_out), 72'(rows[i].err));
			chk(72'(pll_multiplier_out), 72'(rows[i].mult));
			chk(72'({phase_clear_mode_out, upd_mode_out}), 72'({rows[i].pcm, rows[i].upd}));
		end
		// phase keep then phase clear
		i_dpts_host.send(OP_SET_FREQ, 2'h0, 16'h0, 32'h01234567, '0);
		cyc(20);
		i_dpts_host.send(OP_SET_FREQ, 2'h0, 16'h0, 32'h0, '0);
		cyc(6);
		dac_keep = dac_out[9:0];
		i_dpts_host.send(OP_UPD_AUTO, 2'h0, 16'h0, 32'h0, '0);
		cyc(6);
		chk(72'(dac_out[9:0]), 72'(dac_keep));
		i_dpts_host.send(OP_PHASE_CLEAR, 2'h0, 16'h0, 32'h0, '0);
		i_dpts_host.send(OP_UPD_AUTO, 2'h0, 16'h0, 32'h0, '0);
		cyc(6);
		chk(72'(dac_out[9:0]), 72'(dac_out[19:10]));
		i_dpts_host.send(OP_PHASE_KEEP, 2'h0, 16'h0, 32'h0, '0);
		// half-turn offset on channel one mirrors channel zero about mid-scale
		i_dpts_host.send(OP_SET_PHASE, 2'h1, 16'h0, 32'h0000e000, '0);
		cyc(6);
		chk(72'(dac_out[9:0] + dac_out[19:10]), 72'({DAC_MID, 1'b0}));
		// update modes
		base = upd_cnt;
		i_dpts_host.send(OP_SET_AMP, 2'h1, 16'h0, 32'h3ff, '0);
		cyc(4);
		dchk(1);
		i_dpts_host.send(OP_UPD_MANUAL, 2'h0, 16'h0, 32'h0, '0);
		cyc(4);
		base = upd_cnt;
		i_dpts_host.send(OP_SET_AMP, 2'h1, 16'h0, 32'h3ff, '0);
		cyc(6);
		dchk(0);
		i_dpts_host.send(OP_UPD_PULSE, 2'h0, 16'h0, 32'h0, '0);
		cyc(4);
		dchk(1);
		i_dpts_host.send(OP_UPD_EXT, 2'h0, 16'h0, 32'h0, '0);
		cyc(4);
		base = upd_cnt;
		i_dpts_host.send(OP_SET_AMP, 2'h1, 16'h0, 32'h3ff, '0);
		cyc(6);
		dchk(0);
		@(posedge core_clk_in);
		update_trigger_pin <= 1'b1;
		cyc(8);
		dchk(1);
		@(posedge core_clk_in);
		update_trigger_pin <= 1'b0;
		cyc(8);
		dchk(1);
		i_dpts_host.send(OP_UPD_AUTO, 2'h0, 16'h0, 32'h0, '0);
		i_dpts_host.send(OP_SET_FREQ, 2'h2, 16'h0, 32'h04000000, '0);
		// stepping pairs hold, last pair wraps
		i_dpts_host.load_pair(16'h0, 32'h05f5e100, 16'h0, 16'h03ff, 8'h01);
		i_dpts_host.load_pair(16'h1, 32'h05f5e100, 16'h0, 16'h03ff, 8'hff);
		i_dpts_host.load_pair(16'h2, 32'h02faf080, 16'h0, 16'h0200, 8'hff);
		i_dpts_host.load_pair(16'h3, 32'h02faf080, 16'h0, 16'h0200, 8'h00);
		// table run, step, wrap; let the last load's update pass first
		cyc(4);
		base = upd_cnt;
		i_dpts_host.send(OP_MODE_TABLE, 2'h0, 16'h0, 32'h0, '0);
		cyc(4);
		chk(72'({table_mode_out, table_running_out, table_addr_out}), 72'({2'b11, 15'h0}));
		chk(72'(dac_out[39:20]), 72'({2{DAC_MID}}));
		dchk(2);
		wait_addr(15'h1, 2480, 2520);
		// step only once the pair has settled into hold
		cyc(4);
		base = upd_cnt;
		i_dpts_host.send(OP_TABLE_STEP, 2'h0, 16'h0, 32'h0, '0);
		wait_addr(15'h2, 0, 6);
		cyc(4);
		dchk(2);
		@(posedge core_clk_in);
		table_step_pin <= 1'b0;
		wait_addr(15'h3, 0, 12);
		@(posedge core_clk_in);
		table_step_pin <= 1'b1;
		wait_addr(15'h0, 2480, 2520);
		cyc(4);
		i_dpts_host.send(OP_MODE_TABLE, 2'h0, 16'h0, 32'h0, '0);
		cyc(2);
		chk(72'({table_mode_out, table_running_out}), 72'(2'b10));
		i_dpts_host.send(OP_MODE_TABLE, 2'h0, 16'h0, 32'h0, '0);
		cyc(3);
		chk(72'({table_mode_out, table_running_out, table_addr_out}), 72'({2'b11, 15'h0}));
		i_dpts_host.send(OP_READBACK, 2'h1, 16'h2, 32'h0, '0);
		@(negedge core_clk_in);
		chk(72'(rb_valid_out), 72'h1);
		chk(72'(rb_data_out), 72'(dpts_prof_s'{32'h02faf080, 16'h0, 16'h0200, 8'hff}));
		i_dpts_host.send(OP_MODE_SINGLE, 2'h0, 16'h0, 32'h0, '0);
		cyc(2);
		chk(72'({table_mode_out, table_running_out}), 72'(2'b00));
		final_report();
	end
endmodule
`default_nettype wire
